// [verilog/aqc_top.v]
// Acquisition and conversion control: sample buffer, scan list, D/A path, done flags, real-time clock
`timescale 1ns/10ps
`default_nettype none
`include "aqc_regs.vh"

module aqc_top #(
   parameter SAW = 11,
   parameter DAW = 11
) (
   // Clock and reset
   input wire clk_sys_in,
   input wire rst_n_in,
   // Host I/O bus
   input wire [4:0] io_addr_in,
   input wire io_wr_in,
   input wire io_rd_in,
   input wire [15:0] io_wdata_in,
   output reg [15:0] io_rdata_out,
   // A/D converter
   input wire adc_done_in,
   input wire [11:0] adc_result_in,
   output reg adc_start_out,
   output reg [4:0] adc_chan_out,
   output reg [1:0] adc_gain_out,
   // DMA feed of the D/A buffer
   input wire dma_dac_valid_in,
   input wire [15:0] dma_dac_data_in,
   output reg dma_dac_ready_out,
   output reg dac_buf_full_out,
   // D/A converter and synchronous digital outputs
   output reg [11:0] dac_code_out,
   output reg [3:0] sync_dout_out,
   // Pacing timer pins
   input wire timer_ch1_output_in,
   input wire timer_ch2_output_in,
   input wire timer_ch3_output_in,
   input wire timer_ch4_output_in,
   output reg timer_ch2_gate_out,
   output reg timer_src_tick_out,
   // Event mark and external trigger pins
   input wire tag_in,
   input wire xtrg_in,
   // Flags for the interrupt selector
   output reg sample_buffer_empty_n_out,
   output reg sample_buffer_full_out,
   output reg timer1_done_flag_out,
   output reg timer3_done_flag_out,
   output reg timer4_done_flag_out,
   // Real-time clock
   output reg [47:0] rtc_out
);

   localparam integer RTC_LAST = `AQC_RTC_CYC - 1;
   localparam integer SRC_LAST = `AQC_SRC_CYC - 1;
   localparam [4:0] RTC_TOP = RTC_LAST[4:0];
   localparam [4:0] SRC_TOP = SRC_LAST[4:0];

   ////////////////////////////////////////////////////////////////////////
   // Reset release and pin synchronisers
   reg rst_s1_q;
   reg rst_s2_q;
   wire rst_n;
   reg [5:0] pin_s1_q;
   reg [5:0] pin_s2_q;
   reg [5:0] pin_s3_q;
   wire [5:0] pin_rise;

   // Assert at once, release only after two clean edges
   always @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rst_s1_q <= 1'b0;
         rst_s2_q <= 1'b0;
      end else begin
         rst_s1_q <= 1'b1;
         rst_s2_q <= rst_s1_q;
      end
   end
   assign rst_n = rst_s2_q;

   // Pins: {xtrg, tag, ch4, ch3, ch2, ch1}; third stage only feeds edge detect
   always @(posedge clk_sys_in or negedge rst_n) begin
      if (!rst_n) begin
         pin_s1_q <= 6'h00;
         pin_s2_q <= 6'h00;
         pin_s3_q <= 6'h00;
      end else begin
         pin_s1_q <= {xtrg_in, tag_in, timer_ch4_output_in, timer_ch3_output_in,
                      timer_ch2_output_in, timer_ch1_output_in};
         pin_s2_q <= pin_s1_q;
         pin_s3_q <= pin_s2_q;
      end
   end
   assign pin_rise = pin_s2_q & ~pin_s3_q;

   ////////////////////////////////////////////////////////////////////////
   // Bus decode
   wire wr_data = io_wr_in && (io_addr_in == `AQC_OFS_DATA);
   wire wr_ctrl = io_wr_in && (io_addr_in == `AQC_OFS_CTRL);
   wire wr_scan = io_wr_in && (io_addr_in == `AQC_OFS_SCAN);
   wire wr_clr = io_wr_in && (io_addr_in == `AQC_OFS_CLR);
   wire rd_data = io_rd_in && (io_addr_in == `AQC_OFS_DATA);
   wire clr_adc = wr_clr && io_wdata_in[`AQC_CLR_ADC];
   wire conv_start = (wr_clr && io_wdata_in[`AQC_CLR_START]) || pin_rise[1];

   reg [15:0] ctrl_q;

   // Control register steers D/A pacing and split clock
   always @(posedge clk_sys_in or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_q <= `AQC_CTRL_RST;
      end else if (wr_ctrl) begin
         ctrl_q <= io_wdata_in;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Sample buffer
   reg [15:0] smem [0:(1 << SAW) - 1];
   reg [SAW-1:0] s_wr_q;
   reg [SAW-1:0] s_rd_q;
   reg [SAW:0] s_cnt_q;
   reg [SAW:0] s_cnt_d;
   reg tag_q;
   reg xtrg_q;
   wire s_full = s_cnt_q[SAW];
   wire s_push = adc_done_in && !s_full;
   wire s_pop = rd_data && (s_cnt_q != {(SAW+1){1'b0}});
   wire full_set = adc_done_in && (s_full || ((s_cnt_q == {1'b0, {SAW{1'b1}}}) && !s_pop));

   // Occupancy; a flush overrides any push or pop in that cycle
   always @* begin
      s_cnt_d = s_cnt_q;
      if (clr_adc) begin
         s_cnt_d = {(SAW+1){1'b0}};
      end else if (s_push && !s_pop) begin
         s_cnt_d = s_cnt_q + {{SAW{1'b0}}, 1'b1};
      end else if (s_pop && !s_push) begin
         s_cnt_d = s_cnt_q - {{SAW{1'b0}}, 1'b1};
      end
   end

   // Storage holds the mark bits as they stood at conversion end
   always @(posedge clk_sys_in) begin
      if (s_push) begin
         smem[s_wr_q] <= {adc_result_in, 2'b00, xtrg_q, tag_q};
      end
   end

   // Pointers, flags
   always @(posedge clk_sys_in or negedge rst_n) begin
      if (!rst_n) begin
         s_wr_q <= {SAW{1'b0}};
         s_rd_q <= {SAW{1'b0}};
         s_cnt_q <= {(SAW+1){1'b0}};
         sample_buffer_empty_n_out <= 1'b0;
         sample_buffer_full_out <= 1'b0;
         tag_q <= 1'b0;
         xtrg_q <= 1'b0;
      end else begin
         s_cnt_q <= s_cnt_d;
         if (clr_adc) begin
            s_wr_q <= {SAW{1'b0}};
            s_rd_q <= {SAW{1'b0}};
         end else begin
            if (s_push) s_wr_q <= s_wr_q + {{(SAW-1){1'b0}}, 1'b1};
            if (s_pop) s_rd_q <= s_rd_q + {{(SAW-1){1'b0}}, 1'b1};
         end
         // Also drives the interrupt selector
         sample_buffer_empty_n_out <= (s_cnt_d != {(SAW+1){1'b0}});
         // Set beats clear so a result lost in the clear cycle still shows
         sample_buffer_full_out <= full_set ||
            (sample_buffer_full_out && !(clr_adc || rd_data));
         tag_q <= pin_rise[4] || (tag_q && !(clr_adc || rd_data));
         xtrg_q <= pin_rise[5] || (xtrg_q && !(clr_adc || rd_data));
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Scan list
   reg [7:0] scan_mem [0:255];
   reg [7:0] scan_ptr_q;
   wire [7:0] scan_ent = scan_mem[scan_ptr_q];

   // Entry index in low byte, entry itself in high byte
   always @(posedge clk_sys_in) begin
      if (wr_scan) begin
         scan_mem[io_wdata_in[`AQC_SCAN_IDX_LSB +: 8]] <= io_wdata_in[`AQC_SCAN_ENT_LSB +: 8];
      end
   end

   // Each start takes the current entry and steps the pointer
   always @(posedge clk_sys_in or negedge rst_n) begin
      if (!rst_n) begin
         scan_ptr_q <= 8'h00;
         adc_start_out <= 1'b0;
         adc_chan_out <= 5'h00;
         adc_gain_out <= 2'h0;
      end else begin
         adc_start_out <= conv_start;
         if (conv_start) begin
            adc_chan_out <= scan_ent[`AQC_ENT_CHAN_LSB +: 5];
            adc_gain_out <= scan_ent[`AQC_ENT_GAIN_LSB +: 2];
         end
         // Flush has priority over a step in the same cycle
         if (clr_adc) begin
            scan_ptr_q <= 8'h00;
         end else if (conv_start) begin
            scan_ptr_q <= scan_ent[`AQC_ENT_EOL] ? 8'h00 : scan_ptr_q + 8'h01;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // D/A input skid: two words, so a full D/A buffer stalls DMA without loss
   reg [15:0] sk0_q;
   reg [15:0] sk1_q;
   reg [1:0] sk_n_q;
   reg [1:0] sk_n_d;
   reg [DAW:0] d_cnt_q;
   wire d_full = d_cnt_q[DAW];
   wire sk_in = dma_dac_valid_in && dma_dac_ready_out;
   wire sk_out = (sk_n_q != 2'h0) && !d_full;
   wire [1:0] sk_pos = sk_n_q - {1'b0, sk_out};

   // Skid occupancy
   always @* begin
      sk_n_d = sk_n_q;
      if (sk_in && !sk_out) begin
         sk_n_d = sk_n_q + 2'h1;
      end else if (sk_out && !sk_in) begin
         sk_n_d = sk_n_q - 2'h1;
      end
   end

   // Shift on drain, then land the new word at the next free slot
   always @(posedge clk_sys_in or negedge rst_n) begin
      if (!rst_n) begin
         sk0_q <= 16'h0000;
         sk1_q <= 16'h0000;
         sk_n_q <= 2'h0;
         dma_dac_ready_out <= 1'b0;
      end else begin
         sk_n_q <= sk_n_d;
         dma_dac_ready_out <= (sk_n_d != 2'h2);
         if (sk_out) sk0_q <= sk1_q;
         if (sk_in) begin
            if (sk_pos == 2'h0) begin
               sk0_q <= dma_dac_data_in;
            end else begin
               sk1_q <= dma_dac_data_in;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // D/A buffer and converter output
   reg [15:0] dmem [0:(1 << DAW) - 1];
   reg [DAW-1:0] d_wr_q;
   reg [DAW-1:0] d_rd_q;
   reg [DAW:0] d_cnt_d;
   wire dac_pace = ctrl_q[`AQC_CTL_DACSEL] ? pin_rise[0] : pin_rise[1];
   wire d_pop = dac_pace && (d_cnt_q != {(DAW+1){1'b0}});
   wire [15:0] d_word = dmem[d_rd_q];

   // Buffer occupancy
   always @* begin
      d_cnt_d = d_cnt_q;
      if (sk_out && !d_pop) begin
         d_cnt_d = d_cnt_q + {{DAW{1'b0}}, 1'b1};
      end else if (d_pop && !sk_out) begin
         d_cnt_d = d_cnt_q - {{DAW{1'b0}}, 1'b1};
      end
   end

   // Only the skid (DMA) writes the buffer
   always @(posedge clk_sys_in) begin
      if (sk_out) begin
         dmem[d_wr_q] <= sk0_q;
      end
   end

   // Host write wins a same-cycle collision; the paced word is then consumed unseen
   always @(posedge clk_sys_in or negedge rst_n) begin
      if (!rst_n) begin
         d_wr_q <= {DAW{1'b0}};
         d_rd_q <= {DAW{1'b0}};
         d_cnt_q <= {(DAW+1){1'b0}};
         dac_buf_full_out <= 1'b0;
         dac_code_out <= 12'h000;
         sync_dout_out <= 4'h0;
      end else begin
         d_cnt_q <= d_cnt_d;
         dac_buf_full_out <= d_cnt_d[DAW];
         if (sk_out) d_wr_q <= d_wr_q + {{(DAW-1){1'b0}}, 1'b1};
         if (d_pop) d_rd_q <= d_rd_q + {{(DAW-1){1'b0}}, 1'b1};
         if (wr_data) begin
            dac_code_out <= io_wdata_in[`AQC_DATA_CODE_LSB +: 12];
            sync_dout_out <= io_wdata_in[3:0];
         end else if (d_pop) begin
            dac_code_out <= d_word[`AQC_DATA_CODE_LSB +: 12];
            sync_dout_out <= d_word[3:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Done flags, split-clock gate, timer source tick, real-time clock
   reg [4:0] rtc_div_q;
   reg [4:0] src_div_q;
   wire clr_d1 = wr_clr && io_wdata_in[`AQC_CLR_TIMER1_DONE_FLAG];
   wire clr_d3 = wr_clr && io_wdata_in[`AQC_CLR_TIMER3_DONE_FLAG];
   wire clr_d4 = wr_clr && io_wdata_in[`AQC_CLR_TIMER4_DONE_FLAG];

   // Edge sets win over a clear in the same cycle
   always @(posedge clk_sys_in or negedge rst_n) begin
      if (!rst_n) begin
         timer1_done_flag_out <= 1'b0;
         timer3_done_flag_out <= 1'b0;
         timer4_done_flag_out <= 1'b0;
         timer_ch2_gate_out <= 1'b1;
      end else begin
         timer1_done_flag_out <= pin_rise[0] || (timer1_done_flag_out && !clr_d1);
         timer3_done_flag_out <= pin_rise[2] || (timer3_done_flag_out && !clr_d3);
         timer4_done_flag_out <= pin_rise[3] || (timer4_done_flag_out && !clr_d4);
         // Feedback passes the synchroniser, so the rate switch lags three clocks
         timer_ch2_gate_out <= !ctrl_q[`AQC_CTL_SPLIT] || pin_s2_q[2];
      end
   end

   // Dividers for the 250 ns clock and the 4 MHz timer source
   always @(posedge clk_sys_in or negedge rst_n) begin
      if (!rst_n) begin
         rtc_div_q <= 5'h00;
         src_div_q <= 5'h00;
         rtc_out <= 48'h000000000000;
         timer_src_tick_out <= 1'b0;
      end else begin
         if (rtc_div_q == RTC_TOP) begin
            rtc_div_q <= 5'h00;
            rtc_out <= rtc_out + 48'h000000000001;
         end else begin
            rtc_div_q <= rtc_div_q + 5'h01;
         end
         src_div_q <= (src_div_q == SRC_TOP) ? 5'h00 : src_div_q + 5'h01;
         timer_src_tick_out <= (src_div_q == SRC_TOP);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read data, one cycle after the strobe
   wire [15:0] status = {8'h00, sample_buffer_full_out, sample_buffer_empty_n_out, 3'b000,
                         timer4_done_flag_out, timer3_done_flag_out, timer1_done_flag_out};

   // Unmapped offsets and empty-buffer reads answer zero
   always @(posedge clk_sys_in or negedge rst_n) begin
      if (!rst_n) begin
         io_rdata_out <= 16'h0000;
      end else if (io_rd_in) begin
         case (io_addr_in)
            `AQC_OFS_DATA: io_rdata_out <= s_pop ? smem[s_rd_q] : 16'h0000;
            `AQC_OFS_CTRL: io_rdata_out <= ctrl_q;
            `AQC_OFS_STAT: io_rdata_out <= status;
            default: io_rdata_out <= 16'h0000;
         endcase
      end
   end

endmodule // aqc_top
`default_nettype wire

// [verilog/aqc_regs.vh]
// Register map, field positions, reset values and timing counts of the acquisition control block
`ifndef AQC_REGS_VH
`define AQC_REGS_VH

// Register byte offsets on the host I/O bus
`define AQC_OFS_DATA 5'h00
`define AQC_OFS_CTRL 5'h08
`define AQC_OFS_SCAN 5'h0E
`define AQC_OFS_STAT 5'h18
`define AQC_OFS_CLR 5'h1A

// Clear register bits (write one to act)
`define AQC_CLR_TIMER1_DONE_FLAG 0
`define AQC_CLR_TIMER3_DONE_FLAG 1
`define AQC_CLR_TIMER4_DONE_FLAG 2
`define AQC_CLR_ADC 4
`define AQC_CLR_START 7

// Conversion control register bits
`define AQC_CTL_DACSEL 2
`define AQC_CTL_SPLIT 5
`define AQC_CTRL_RST 16'h0000

// Status register bits
`define AQC_ST_TIMER1_DONE_FLAG 0
`define AQC_ST_TIMER3_DONE_FLAG 1
`define AQC_ST_TIMER4_DONE_FLAG 2
`define AQC_ST_EMPTY_N 6
`define AQC_ST_FULL 7

// Scan list word fields
`define AQC_SCAN_IDX_LSB 0
`define AQC_SCAN_ENT_LSB 8
`define AQC_ENT_CHAN_LSB 0
`define AQC_ENT_GAIN_LSB 5
`define AQC_ENT_EOL 7

// Data word fields
`define AQC_DATA_CODE_LSB 4
`define AQC_DATA_TAG 0
`define AQC_DATA_XTRG 1

// Timing
`define AQC_CLK_NS 10
`define AQC_RTC_NS 250
`define AQC_SRC_MHZ 4
`define AQC_RTC_CYC (`AQC_RTC_NS / `AQC_CLK_NS)
`define AQC_SRC_CYC (1000 / (`AQC_SRC_MHZ * `AQC_CLK_NS))

`endif

// [verif/aqc_chk.sv]
// Port checker of the acquisition control block
`timescale 1ns/10ps
`default_nettype none
`include "aqc_regs.vh"
module aqc_chk (
   // Clock, reset and host bus
   input wire logic clk_sys_in,
   input wire logic rst_n_in,
   input wire logic [4:0] io_addr_in,
   input wire logic io_wr_in,
   input wire logic io_rd_in,
   input wire logic [15:0] io_wdata_in,
   // Converter side, flags and time base
   input wire logic adc_done_in,
   input wire logic adc_start_out,
   input wire logic [4:0] adc_chan_out,
   input wire logic [11:0] dac_code_out,
   input wire logic [3:0] sync_dout_out,
   input wire logic timer_ch1_output_in,
   input wire logic timer_src_tick_out,
   input wire logic sample_buffer_empty_n_out,
   input wire logic sample_buffer_full_out,
   input wire logic timer1_done_flag_out,
   input wire logic [47:0] rtc_out
);
   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (!rst_n_in);
   ////////////////////////////////////////
   // Decoded clear writes and data reads; flush outranks a same-cycle push
   wire clr_w = io_wr_in && (io_addr_in == `AQC_OFS_CLR);
   wire flush_w = clr_w && io_wdata_in[`AQC_CLR_ADC];
   wire rd_dat = io_rd_in && (io_addr_in == `AQC_OFS_DATA);
   ////////////////////////////////////////
   chk_start_on_write: assert property (clr_w && io_wdata_in[`AQC_CLR_START] |=> adc_start_out)
      else $error("start pulse missing after software strobe");
   chk_chan_with_start: assert property ($changed(adc_chan_out) |-> adc_start_out)
      else $error("channel moved without a start");
   chk_push_not_empty: assert property (adc_done_in && !flush_w |=> sample_buffer_empty_n_out)
      else $error("buffer still empty after a result");
   chk_flush_clears: assert property (flush_w && !adc_done_in |=> !sample_buffer_empty_n_out && !sample_buffer_full_out)
      else $error("flush left buffer flags set");
   chk_read_clears_full: assert property (rd_dat && !adc_done_in |=> !sample_buffer_full_out)
      else $error("full flag survived a data read");
   chk_dac_host_write: assert property (io_wr_in && io_addr_in == `AQC_OFS_DATA
      |=> {dac_code_out, sync_dout_out} == $past(io_wdata_in))
      else $error("host write did not reach converter");
   chk_timer1_done_flag_set: assert property ($rose(timer_ch1_output_in) |-> ##[2:6] timer1_done_flag_out)
      else $error("channel 1 done flag not set");
   chk_tick_period: assert property (timer_src_tick_out |=> !timer_src_tick_out [*8] ##17 timer_src_tick_out)
      else $error("source tick period wrong");
   chk_rtc_step: assert property ($changed(rtc_out) |-> (rtc_out == $past(rtc_out) + 48'h1) ##25 $changed(rtc_out))
      else $error("clock counter step wrong");
endmodule // aqc_chk
bind aqc_top aqc_chk aqc_chk_inst (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .io_addr_in(io_addr_in),
   .io_wr_in(io_wr_in), .io_rd_in(io_rd_in), .io_wdata_in(io_wdata_in), .adc_done_in(adc_done_in),
   .adc_start_out(adc_start_out), .adc_chan_out(adc_chan_out), .dac_code_out(dac_code_out),
   .sync_dout_out(sync_dout_out), .timer_ch1_output_in(timer_ch1_output_in),
   .timer_src_tick_out(timer_src_tick_out), .sample_buffer_empty_n_out(sample_buffer_empty_n_out),
   .sample_buffer_full_out(sample_buffer_full_out), .timer1_done_flag_out(timer1_done_flag_out),
   .rtc_out(rtc_out));
`default_nettype wire

// [verif/aqc_far_model.sv]
// Far-side model: A/D converter and DMA word source
`timescale 1ns/10ps
`default_nettype none
module aqc_far_model (
   // Clock and controls
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic slow_in,
   input wire logic dma_go_in,
   // Converter
   input wire logic start_in,
   input wire logic [4:0] chan_in,
   input wire logic [1:0] gain_in,
   output logic done_out,
   output logic [11:0] result_out,
   // DMA feed
   input wire logic ready_in,
   output logic valid_out,
   output logic [15:0] data_out
);
   int seq;
   int wait_c;
   int k;
   ////////////////////////////////////////
   // Result carries entry and sequence so order is visible; line scrambled once done
   always @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         seq <= 0;
         wait_c <= 0;
         done_out <= 1'b0;
         result_out <= 12'h000;
      end else begin
         done_out <= 1'b0;
         if (done_out) result_out <= ~result_out;
         if (start_in) begin
            wait_c <= slow_in ? 9 : 2;
            result_out <= {gain_in, chan_in, seq[4:0]};
            seq <= seq + 1;
         end else if (wait_c == 1) begin
            done_out <= 1'b1;
            wait_c <= 0;
         end else if (wait_c > 1) begin
            wait_c <= wait_c - 1;
         end
      end
   end
   ////////////////////////////////////////
   // Word held until taken; data inverted once released
   always @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         k <= 0;
         valid_out <= 1'b0;
         data_out <= 16'h0000;
      end else if (valid_out && ready_in) begin
         k <= k + 1;
         valid_out <= 1'b0;
         data_out <= ~data_out;
      end else if (!valid_out && dma_go_in) begin
         valid_out <= 1'b1;
         data_out <= {k[11:0], k[3:0]};
      end
   end
endmodule // aqc_far_model
`default_nettype wire

// [verif/tb_acquisition_conversion_control.sv]
// Self-checking bench of the acquisition control block
`timescale 1ns/10ps
`default_nettype none
`include "aqc_regs.vh"
module tb_acquisition_conversion_control;
   logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd_s = 1'b0, tag = 1'b0, xtrg = 1'b0, slow = 1'b0, go = 1'b0, rd_d = 1'b0;
   logic [4:0] addr = 5'h00;
   logic [15:0] wdata = 16'h0000;
   logic [3:0] tp = 4'h0;
   wire done, valid, ready, dfull, start, gate;
   wire [11:0] res, code;
   wire [15:0] rdata, ddata;
   wire [4:0] chan;
   wire [1:0] gain;
   wire [3:0] dout;
   wire [4:0] flags;
   logic [15:0] exp_q[$], sq[$], w;
   logic [7:0] ent[0:3];
   int bad_count, total_checks, starts, acc, p, i, j, n;
   ////////////////////////////////////////
   always #5 clk = ~clk;
   aqc_top #(.SAW(4), .DAW(4)) aqc_top_inst (.clk_sys_in(clk), .rst_n_in(rst_n), .io_addr_in(addr),
      .io_wr_in(wr), .io_rd_in(rd_s), .io_wdata_in(wdata), .io_rdata_out(rdata), .adc_done_in(done),
      .adc_result_in(res), .adc_start_out(start), .adc_chan_out(chan), .adc_gain_out(gain),
      .dma_dac_valid_in(valid), .dma_dac_data_in(ddata), .dma_dac_ready_out(ready), .dac_buf_full_out(dfull),
      .dac_code_out(code), .sync_dout_out(dout), .timer_ch1_output_in(tp[0]), .timer_ch2_output_in(tp[1]),
      .timer_ch3_output_in(tp[2]), .timer_ch4_output_in(tp[3]), .timer_ch2_gate_out(gate),
      .timer_src_tick_out(), .tag_in(tag), .xtrg_in(xtrg), .sample_buffer_empty_n_out(flags[0]),
      .sample_buffer_full_out(flags[1]), .timer1_done_flag_out(flags[2]), .timer3_done_flag_out(flags[3]),
      .timer4_done_flag_out(flags[4]), .rtc_out());
   aqc_far_model aqc_far_model_inst (.clk_in(clk), .rst_n_in(rst_n), .slow_in(slow), .dma_go_in(go),
      .start_in(start), .chan_in(chan), .gain_in(gain), .done_out(done), .result_out(res),
      .ready_in(ready), .valid_out(valid), .data_out(ddata));
   ////////////////////////////////////////
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      total_checks++;
      if (g !== e) begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wt(input int c);
      repeat (c) @(posedge clk);
   endtask
   // Each access spans two edges so strobes never re-assert in one step
   task automatic wrt(input logic [4:0] a, input logic [15:0] d);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      wt(1);
      wr <= 1'b0;
      wt(1);
   endtask
   task automatic rd(input logic [4:0] a, input logic [15:0] e);
      exp_q.push_back(e);
      addr <= a;
      rd_s <= 1'b1;
      wt(1);
      rd_s <= 1'b0;
      wt(1);
   endtask
   task automatic rdd;
      rd(`AQC_OFS_DATA, sq.size() ? sq.pop_front() : 16'h0000);
   endtask
   task automatic flush;
      wrt(`AQC_OFS_CLR, 16'h0010);
      sq.delete();
      p = 0;
   endtask
   task automatic pulse(input int k);
      tp[k] <= 1'b1;
      wt(3);
      tp[k] <= 1'b0;
      wt(4);
   endtask
   // One conversion by software strobe or pacing pin; expected sample noted
   task automatic conv(input bit sw, input logic [1:0] mk);
      logic [11:0] r;
      r = {ent[p][6:0], starts[4:0]};
      slow <= 1'($urandom);
      if (sw) wrt(`AQC_OFS_CLR, 16'h0080);
      else tp[1] <= 1'b1;
      for (n = 0; n < 12 && start !== 1'b1; n++) wt(1);
      tp[1] <= 1'b0;
      chk("entry", {9'h0, ent[p][6:0]}, {9'h0, gain, chan});
      p = ent[p][7] ? 0 : p + 1;
      for (n = 0; n < 20 && done !== 1'b1; n++) wt(1);
      wt(2);
      if (sq.size() < 16) sq.push_back({r, 2'b00, mk});
   endtask
   task automatic results;
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   ////////////////////////////////////////
   // Read results compared one edge after the strobe, oldest note first
   always @(posedge clk) begin
      rd_d <= rd_s;
      if (rd_d) chk("read", exp_q.pop_front(), rdata);
      if (start === 1'b1) starts++;
      if (valid && ready) acc++;
   end
   // Run needs under a thousand cycles; generous margin
   initial begin
      wt(20000);
      bad_count++;
      results();
   end
   initial begin
      void'($urandom(32'hA3795336));
      wt(2);
      rst_n <= 1'b1;
      wt(4);
      rd(`AQC_OFS_STAT, 16'h0000);
      rd(5'h02, 16'h0000);
      wrt(5'h1C, 16'hFFFF);
      rdd();
      for (i = 0; i < 4; i++) begin
         ent[i] = {i == 2, 7'($urandom)};
         wrt(`AQC_OFS_SCAN, {ent[i], i[7:0]});
      end
      conv(1, 2'b00);
      rd(`AQC_OFS_STAT, 16'h0040);
      repeat (3) conv(1, 2'b00);
      repeat (4) rdd();
      rd(`AQC_OFS_STAT, 16'h0000);
      conv(1, 2'b00);
      conv(0, 2'b00);
      flush();
      rd(`AQC_OFS_STAT, 16'h0000);
      tag <= 1'b1;
      xtrg <= 1'b1;
      wt(3);
      tag <= 1'b0;
      xtrg <= 1'b0;
      wt(4);
      repeat (2) conv(1, 2'b11);
      rdd();
      conv(1, 2'b00);
      repeat (2) rdd();
      ent[0] = 8'hFF;
      wrt(`AQC_OFS_SCAN, 16'hFF00);
      flush();
      repeat (17) conv(1, 2'b00);
      rd(`AQC_OFS_STAT, 16'h00C0);
      rdd();
      rd(`AQC_OFS_STAT, 16'h0040);
      flush();
      rd(`AQC_OFS_STAT, 16'h0000);
      wrt(`AQC_OFS_CTRL, 16'h0020);
      rd(`AQC_OFS_CTRL, 16'h0020);
      tp[2] <= 1'b1;
      wt(6);
      chk("gate", 16'h0001, {15'h0, gate});
      tp[2] <= 1'b0;
      wt(6);
      chk("gate", 16'h0000, {15'h0, gate});
      wrt(`AQC_OFS_CTRL, 16'h0000);
      wt(4);
      chk("gate", 16'h0001, {15'h0, gate});
      pulse(0);
      pulse(3);
      rd(`AQC_OFS_STAT, 16'h0007);
      wrt(`AQC_OFS_CLR, 16'h0000);
      rd(`AQC_OFS_STAT, 16'h0007);
      wrt(`AQC_OFS_CLR, 16'h0002);
      rd(`AQC_OFS_STAT, 16'h0005);
      wrt(`AQC_OFS_CLR, 16'h0005);
      rd(`AQC_OFS_STAT, 16'h0000);
      repeat (3) begin
         w = 16'($urandom);
         wrt(`AQC_OFS_DATA, w);
         chk("dac", w, {code, dout});
      end
      go <= 1'b1;
      // Feed until the skid is full too, so a word is left waiting on ready
      for (n = 0; n < 100 && ready !== 1'b0; n++) wt(1);
      go <= 1'b0;
      wt(6);
      chk("stall", 16'h0010, {11'h0, dfull, 3'h0, ready});
      pulse(0);
      chk("dac", w, {code, dout});
      pulse(1);
      chk("dma", 16'h0000, {code, dout});
      wrt(`AQC_OFS_CTRL, 16'h0004);
      for (j = 1; j < acc && j < 40; j++) begin
         pulse(0);
         chk("dma", {j[11:0], j[3:0]}, {code, dout});
      end
      // 16 buffered, 2 in the skid, 1 held by the source: 19 words, none lost
      chk("drain", 16'h0003, {11'h0, dfull, acc[3:0]});
      flush();
      results();
   end
endmodule // tb_acquisition_conversion_control
`default_nettype wire
